/* include/usc_defines.svh */
// constants for the serial status and command section
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH
// command byte bit positions
`define USC_CMD_TRANSMIT_ENABLE_BIT      0
`define USC_CMD_DTR       1
`define USC_CMD_RXEN      2
`define USC_CMD_BRK       3
`define USC_CMD_ERRCLR    4
`define USC_CMD_RTS       5
`define USC_CMD_SRST      6
`define USC_CMD_HUNT      7
// status byte bit positions
`define USC_ST_TRANSMIT_HOLDING_FREE      0
`define USC_ST_RXRDY      1
`define USC_ST_TXEMPTY    2
`define USC_ST_PARERR     3
`define USC_ST_OVRERR     4
`define USC_ST_FRMERR     5
`define USC_ST_SYNDET     6
`define USC_ST_DSR        7
// reset value of the command byte
`define USC_CMD_RESET     8'h00
// reset value of the status snapshot and the read data
`define USC_STATUS_RESET  8'h00
// longest status update delay in clock periods
`define USC_UPD_MAX_BASE  16
`define USC_UPD_MAX_ENH   28
`endif

/* include/usc_pkg.sv */
// types for the serial status and command section
package usc_pkg;
    typedef enum logic [2:0] {
        USC_MODE_WAIT = 3'b001,
        USC_SYNC_WAIT = 3'b010,
        USC_CMD_READY = 3'b100
    } usc_phase_type;
endpackage

/* include/usc_flag_if.sv */
// flag set and clear signals between the control and a sticky flag
`timescale 1ns/100ps
interface usc_flag_if;
    logic setPulse;
    logic clearPulse;
    logic flagLevel;
    modport ctrl (output setPulse, output clearPulse, input flagLevel);
    modport flag (input setPulse, input clearPulse, output flagLevel);
endinterface

/* src/usc_sticky_flag.sv */
// one sticky error flag
`timescale 1ns/100ps
module usc_sticky_flag
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // flag port
    usc_flag_if.flag  flagPort
);
    logic flag_ff;
    logic nxt_flag;

    // set wins over a clear in the same cycle
    always_comb
    begin
        nxt_flag = flag_ff;
        if (flagPort.clearPulse)
        begin
            nxt_flag = 1'b0;
        end
        if (flagPort.setPulse)
        begin
            nxt_flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            flag_ff <= 1'b0;
        end
        else
        begin
            flag_ff <= nxt_flag;
        end
    end

    assign flagPort.flagLevel = flag_ff;
endmodule // usc_sticky_flag

/* src/usc_status_command.sv */
// status read and command write section of the serial transceiver
`timescale 1ns/100ps
`include "usc_defines.svh"
module usc_status_command
    import usc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // processor bus, strobes are one clock pulses
    input  wire logic       ctrlSelect,
    input  wire logic       writeStrobe,
    input  wire logic       readStrobe,
    input  wire logic [7:0] writeData,
    output logic      [7:0] readData,
    // mode information from the mode decoder
    input  wire logic [1:0] syncCharCount,
    input  wire logic       internalSync,
    // receiver and transmitter events
    input  wire logic       parityErrSet,
    input  wire logic       frameErrSet,
    input  wire logic       charReceived,
    input  wire logic       charFetched,
    input  wire logic       bufferEmpty,
    input  wire logic       txShiftEmpty,
    input  wire logic       syncMatched,
    input  wire logic       serialTxIn,
    // modem inputs
    input  wire logic       clearToSend_n,
    input  wire logic       dataSetReady_n,
    // outputs to transceiver and pins
    output logic            modeWrite,
    output logic            syncWrite,
    output logic            receiverEnable,
    output logic            transmitterEnable,
    output logic            huntActive,
    output logic            serialTxOut,
    output logic            requestToSend_n,
    output logic            terminalReady_n,
    output logic            transmitHoldingFree,
    output logic            receiveReady
);
    usc_phase_type phase_ff;
    usc_phase_type nxt_phase;
    logic [1:0]    syncLeft_ff;
    logic [1:0]    nxt_syncLeft;
    logic [7:0]    cmd_ff;
    logic [7:0]    nxt_cmd;
    logic          hunt_ff;
    logic          nxt_hunt;
    logic          rxFull_ff;
    logic          nxt_rxFull;
    logic          syndet_ff;
    logic          nxt_syndet;
    logic [7:0]    status_ff;
    logic [7:0]    nxt_status;
    logic [7:0]    readData_ff;
    logic [7:0]    nxt_readData;
    logic          ctrlWrite;
    logic          cmdWrite;
    logic          errClear;

    usc_flag_if parityIf();
    usc_flag_if overrunIf();
    usc_flag_if frameIf();

    // strobes with control select low are data accesses and belong elsewhere
    assign ctrlWrite = writeStrobe & ctrlSelect;
    assign cmdWrite  = ctrlWrite & (phase_ff == USC_CMD_READY);
    // a set in the same cycle still wins inside each flag
    // clear all errors
    assign errClear  = cmdWrite & writeData[`USC_CMD_ERRCLR];

    assign parityIf.setPulse    = parityErrSet;
    assign parityIf.clearPulse  = errClear;
    // a fetch in the same cycle frees the buffer, so that is no overrun
    // overrun when previous char unread
    assign overrunIf.setPulse   = charReceived & rxFull_ff & ~charFetched;
    assign overrunIf.clearPulse = errClear;
    assign frameIf.setPulse     = frameErrSet;
    assign frameIf.clearPulse   = errClear;

    // one sticky flag per error, all three share the clear strobe
    usc_sticky_flag u_parity
    (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .flagPort (parityIf.flag)
    );
    usc_sticky_flag u_overrun
    (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .flagPort (overrunIf.flag)
    );
    usc_sticky_flag u_frame
    (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .flagPort (frameIf.flag)
    );

    // setup phase and command register
    // the sync count is taken only with the mode write, later changes are ignored
    always_comb
    begin
        nxt_phase    = phase_ff;
        nxt_syncLeft = syncLeft_ff;
        nxt_cmd      = cmd_ff;
        case (phase_ff)
            USC_MODE_WAIT:
            begin
                if (ctrlWrite)
                begin
                    nxt_syncLeft = syncCharCount;
                    nxt_phase    = (syncCharCount == 2'h0) ? USC_CMD_READY : USC_SYNC_WAIT;
                end
            end
            USC_SYNC_WAIT:
            begin
                // one sync byte per control write until none are owed
                if (ctrlWrite)
                begin
                    nxt_syncLeft = syncLeft_ff - 2'h1;
                    if (syncLeft_ff == 2'h1)
                    begin
                        nxt_phase = USC_CMD_READY;
                    end
                end
            end
            USC_CMD_READY:
            begin
                if (cmdWrite)
                begin
                    nxt_cmd = writeData;
                    // the rest of a soft reset byte is dropped, a new mode write follows
                    // soft reset returns to mode
                    if (writeData[`USC_CMD_SRST])
                    begin
                        nxt_phase = USC_MODE_WAIT;
                        nxt_cmd   = `USC_CMD_RESET;
                    end
                end
            end
            default:
            begin
                // an illegal phase code falls back to waiting for a mode
                nxt_phase = USC_MODE_WAIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            phase_ff    <= USC_MODE_WAIT;
            syncLeft_ff <= 2'h0;
            cmd_ff      <= `USC_CMD_RESET;
        end
        else
        begin
            phase_ff    <= nxt_phase;
            syncLeft_ff <= nxt_syncLeft;
            cmd_ff      <= nxt_cmd;
        end
    end

    // receiver bookkeeping, hunt and sync detect
    always_comb
    begin
        nxt_hunt   = hunt_ff;
        nxt_rxFull = rxFull_ff;
        nxt_syndet = syndet_ff;
        // external sync needs no search, so hunt is only entered with internal sync
        // enter search on hunt bit
        if (cmdWrite & writeData[`USC_CMD_HUNT] & internalSync)
        begin
            nxt_hunt = 1'b1;
        end
        else if (syncMatched)
        begin
            nxt_hunt = 1'b0;
        end
        // a status read hands the detect to the host, so it drops
        if (readStrobe & ctrlSelect)
        begin
            nxt_syndet = 1'b0;
        end
        // a detect landing on the status read wins
        if (hunt_ff & syncMatched)
        begin
            nxt_syndet = 1'b1;
        end
        // a char arriving with a fetch keeps the buffer full
        if (charFetched)
        begin
            nxt_rxFull = 1'b0;
        end
        if (charReceived)
        begin
            nxt_rxFull = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            hunt_ff   <= 1'b0;
            rxFull_ff <= 1'b0;
            syndet_ff <= 1'b0;
        end
        else
        begin
            hunt_ff   <= nxt_hunt;
            rxFull_ff <= nxt_rxFull;
            syndet_ff <= nxt_syndet;
        end
    end

    // status snapshot and read data
    // the snapshot adds one clock of lag but keeps the pins off the read path
    always_comb
    begin
        nxt_status                   = 8'h00;
        // status bit is buffer empty only
        nxt_status[`USC_ST_TRANSMIT_HOLDING_FREE]    = bufferEmpty;
        nxt_status[`USC_ST_RXRDY]    = rxFull_ff;
        nxt_status[`USC_ST_TXEMPTY]  = txShiftEmpty & bufferEmpty;
        nxt_status[`USC_ST_PARERR]   = parityIf.flagLevel;
        nxt_status[`USC_ST_OVRERR]   = overrunIf.flagLevel;
        nxt_status[`USC_ST_FRMERR]   = frameIf.flagLevel;
        nxt_status[`USC_ST_SYNDET]   = syndet_ff;
        nxt_status[`USC_ST_DSR]      = ~dataSetReady_n;
        nxt_readData                 = readData_ff;
        if (readStrobe & ctrlSelect)
        begin
            nxt_readData = status_ff;
        end
    end

    // two clock update path, well inside the limit
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            status_ff   <= `USC_STATUS_RESET;
            readData_ff <= `USC_STATUS_RESET;
        end
        else
        begin
            status_ff   <= nxt_status;
            readData_ff <= nxt_readData;
        end
    end

    // read data holds between status reads, a data read leaves it alone
    assign readData           = readData_ff;
    // markers are combinational so the mode and sync loaders see the write in its own cycle
    assign modeWrite          = ctrlWrite & (phase_ff == USC_MODE_WAIT);
    assign syncWrite          = ctrlWrite & (phase_ff == USC_SYNC_WAIT);
    assign receiverEnable     = cmd_ff[`USC_CMD_RXEN];
    assign transmitterEnable  = cmd_ff[`USC_CMD_TRANSMIT_ENABLE_BIT];
    assign huntActive         = hunt_ff;
    // gating after the shifter lets a break start or stop mid character
    // break forces low
    assign serialTxOut        = serialTxIn & ~cmd_ff[`USC_CMD_BRK];
    // command bits are kept high-true, the pins are inverted here
    // active low modem outputs
    assign requestToSend_n    = ~cmd_ff[`USC_CMD_RTS];
    assign terminalReady_n    = ~cmd_ff[`USC_CMD_DTR];
    assign transmitHoldingFree = bufferEmpty & ~clearToSend_n & cmd_ff[`USC_CMD_TRANSMIT_ENABLE_BIT];
    // same level as the status bit, for hosts that poll the pin
    assign receiveReady       = rxFull_ff;
endmodule // usc_status_command

/* test/usc_status_command_chk.sv */
// port assertions for the status and command section
`timescale 1ns/100ps
`include "usc_defines.svh"
module usc_status_command_chk
(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    // processor bus
    input wire logic       ctrlSelect,
    input wire logic       writeStrobe,
    input wire logic       readStrobe,
    input wire logic [7:0] writeData,
    input wire logic [7:0] readData,
    // events and pins
    input wire logic       parityErrSet,
    input wire logic       bufferEmpty,
    input wire logic       syncMatched,
    input wire logic       clearToSend_n,
    input wire logic       modeWrite,
    input wire logic       syncWrite,
    input wire logic       receiverEnable,
    input wire logic       transmitterEnable,
    input wire logic       huntActive,
    input wire logic       serialTxOut,
    input wire logic       requestToSend_n,
    input wire logic       terminalReady_n,
    input wire logic       transmitHoldingFree
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // control writes past the mode and sync phase
    wire ctlWr = writeStrobe && ctrlSelect && !modeWrite && !syncWrite;
    wire cmdWr = ctlWr && !writeData[6];
    wire rd    = readStrobe && ctrlSelect;
    a_modem_pins: assert property (
        cmdWr |=> requestToSend_n == !$past(writeData[5]) && terminalReady_n == !$past(writeData[1]))
        else $error("modem pins wrong");
    a_enable_bits: assert property (
        cmdWr |=> receiverEnable == $past(writeData[2]) && transmitterEnable == $past(writeData[0]))
        else $error("enables wrong");
    a_break_low: assert property (
        cmdWr && writeData[3] |=> !serialTxOut) else $error("break not low");
    a_ready_pin: assert property (
        transmitHoldingFree == (bufferEmpty && !clearToSend_n && transmitterEnable)) else $error("ready pin wrong");
    a_read_hold: assert property (
        !rd |=> $stable(readData)) else $error("read data moved");
    a_soft_reset: assert property (
        ctlWr && writeData[6] |=> requestToSend_n && terminalReady_n && !receiverEnable) else $error("soft reset");
    a_hunt_leave: assert property (
        huntActive && syncMatched && !writeStrobe |=> !huntActive) else $error("hunt kept");
    // an error clear one cycle after the set would legally empty the snapshot
    a_parity_seen: assert property (
        parityErrSet ##1 !ctlWr ##2 rd |=> readData[`USC_ST_PARERR]) else $error("parity not seen");
endmodule // usc_status_command_chk

bind usc_status_command usc_status_command_chk usc_status_command_chk_i (.*);

/* test/usc_host_model.sv */
// host processor model on the control and data bus
`timescale 1ns/100ps
module usc_host_model
(
    // clock
    input wire logic       ref_clk,
    // bus toward the device
    output logic           ctrlSelect,
    output logic           writeStrobe,
    output logic           readStrobe,
    output logic     [7:0] writeData,
    // answers
    input wire logic [7:0] readData,
    input wire logic       modeWrite,
    input wire logic       syncWrite
);
    initial
    begin
        ctrlSelect  = 1'h0;
        writeStrobe = 1'h0;
        readStrobe  = 1'h0;
        writeData   = 8'h00;
    end
    // control write, returning the mode and sync markers seen with the strobe
    task automatic wr(input logic [7:0] v, output logic m, output logic s);
        @(posedge ref_clk);
        ctrlSelect  <= 1'h1;
        writeStrobe <= 1'h1;
        writeData   <= v;
        #1;
        m = modeWrite;
        s = syncWrite;
        @(posedge ref_clk);
        writeStrobe <= 1'h0;
        // released data must not look like the last byte
        writeData   <= ~v;
    endtask
    // data-side access with control select low, which the status section must ignore
    task automatic dacc(input logic wrNotRd, input logic [7:0] v);
        @(posedge ref_clk);
        ctrlSelect  <= 1'h0;
        writeStrobe <= wrNotRd;
        readStrobe  <= ~wrNotRd;
        writeData   <= v;
        @(posedge ref_clk);
        ctrlSelect  <= 1'h1;
        writeStrobe <= 1'h0;
        readStrobe  <= 1'h0;
        writeData   <= ~v;
    endtask
    task automatic rd(output logic [7:0] v);
        @(posedge ref_clk);
        ctrlSelect <= 1'h1;
        readStrobe <= 1'h1;
        @(posedge ref_clk);
        readStrobe <= 1'h0;
        #1;
        v = readData;
    endtask
endmodule // usc_host_model

/* test/test_usc_status_command.sv */
// self-checking bench for the status and command section
`timescale 1ns/100ps
module test_usc_status_command;
    logic       ref_clk        = 1'h0;
    logic       sys_rst        = 1'h1;
    logic [1:0] syncCharCount  = 2'h0;
    logic       internalSync   = 1'h0;
    // pulses: fetch, sync match, char, framing, parity
    logic [4:0] ev             = 5'h00;
    logic       bufferEmpty    = 1'h1;
    logic       txShiftEmpty   = 1'h1;
    logic       serialTxIn     = 1'h1;
    logic       clearToSend_n  = 1'h0;
    logic       dataSetReady_n = 1'h0;
    logic       ctrlSelect, writeStrobe, readStrobe, modeWrite, syncWrite, receiverEnable, transmitterEnable;
    logic       huntActive, serialTxOut, requestToSend_n, terminalReady_n, transmitHoldingFree, receiveReady;
    logic       m, s;
    logic [7:0] writeData, readData, d;
    int         n_errors   = 0;
    int         n_compared = 0;
    usc_host_model usc_host_model_i (.*);
    usc_status_command usc_status_command_i (.*, .parityErrSet(ev[0]), .frameErrSet(ev[1]), .charReceived(ev[2]),
        .syncMatched(ev[3]), .charFetched(ev[4]));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one-cycle event, then one idle cycle so flags reach the snapshot
    task automatic pulse(input logic [4:0] p);
        @(posedge ref_clk);
        ev <= p;
        @(posedge ref_clk);
        ev <= 5'h00;
        @(posedge ref_clk);
    endtask
    function automatic logic [7:0] st(input logic pe, oe, fe, rx, sd);
        return {~dataSetReady_n, sd, fe, oe, pe, bufferEmpty & txShiftEmpty, rx, bufferEmpty};
    endfunction
    task automatic t_cmd;
        logic [7:0] p [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h2F};
        usc_host_model_i.wr(8'h4E, m, s);
        check("mode", {6'h00, m, s}, 8'h02);
        foreach (p[i])
        begin
            usc_host_model_i.wr(p[i], m, s);
            #1;
            d = {3'h0, serialTxOut, requestToSend_n, terminalReady_n, receiverEnable, transmitterEnable};
            check("cmd", d, {3'h0, ~p[i][3], ~p[i][5], ~p[i][1], p[i][2], p[i][0]});
        end
        $display("cmd done");
    endtask
    task automatic t_transmit_holding_free;
        usc_host_model_i.wr(8'h01, m, s);
        #1;
        check("rdy", {7'h00, transmitHoldingFree}, 8'h01);
        @(posedge ref_clk);
        clearToSend_n <= 1'h1;
        @(posedge ref_clk);
        #1;
        check("rdy", {7'h00, transmitHoldingFree}, 8'h00);
        usc_host_model_i.rd(d);
        check("st", d, st(0, 0, 0, 0, 0));
        @(posedge ref_clk);
        bufferEmpty    <= 1'h0;
        dataSetReady_n <= 1'h1;
        @(posedge ref_clk);
        usc_host_model_i.rd(d);
        check("st", d, st(0, 0, 0, 0, 0));
        @(posedge ref_clk);
        bufferEmpty    <= 1'h1;
        dataSetReady_n <= 1'h0;
        clearToSend_n  <= 1'h0;
        txShiftEmpty   <= 1'h0;
        @(posedge ref_clk);
        usc_host_model_i.rd(d);
        check("st", d, st(0, 0, 0, 0, 0));
        @(posedge ref_clk);
        txShiftEmpty   <= 1'h1;
        $display("transmit_holding_free done");
    endtask
    task automatic t_errors;
        pulse(5'h01);
        usc_host_model_i.rd(d);
        check("st", d, st(1, 0, 0, 0, 0));
        pulse(5'h02);
        pulse(5'h04);
        check("rxrdy", {7'h00, receiveReady}, 8'h01);
        pulse(5'h04);
        usc_host_model_i.rd(d);
        check("st", d, st(1, 1, 1, 1, 0));
        usc_host_model_i.wr(8'h10, m, s);
        #1;
        check("rdy", {7'h00, transmitHoldingFree}, 8'h00);
        @(posedge ref_clk);
        usc_host_model_i.rd(d);
        check("st", d, st(0, 0, 0, 1, 0));
        pulse(5'h10);
        usc_host_model_i.rd(d);
        check("st", d, st(0, 0, 0, 0, 0));
        check("rxrdy", {7'h00, receiveReady}, 8'h00);
        // a new char together with a fetch is no overrun
        pulse(5'h04);
        pulse(5'h14);
        usc_host_model_i.rd(d);
        check("st", d, st(0, 0, 0, 1, 0));
        pulse(5'h10);
        $display("errors done");
    endtask
    task automatic t_hunt;
        @(posedge ref_clk);
        internalSync <= 1'h1;
        usc_host_model_i.wr(8'h80, m, s);
        #1;
        check("hunt", {7'h00, huntActive}, 8'h01);
        pulse(5'h08);
        #1;
        check("hunt", {7'h00, huntActive}, 8'h00);
        // a data read must neither capture status nor drop the sync detect
        usc_host_model_i.dacc(1'h0, 8'h00);
        #1;
        check("dread", readData, st(0, 0, 0, 1, 0));
        usc_host_model_i.rd(d);
        check("st", d, st(0, 0, 0, 0, 1));
        @(posedge ref_clk);
        usc_host_model_i.rd(d);
        check("st", d, st(0, 0, 0, 0, 0));
        $display("hunt done");
    endtask
    task automatic t_soft;
        usc_host_model_i.wr(8'h63, m, s);
        #1;
        check("srst", {4'h0, requestToSend_n, terminalReady_n, receiverEnable, transmitterEnable}, 8'h0C);
        @(posedge ref_clk);
        syncCharCount <= 2'h1;
        usc_host_model_i.wr(8'h4E, m, s);
        check("mode", {6'h00, m, s}, 8'h02);
        usc_host_model_i.wr(8'h16, m, s);
        check("sync", {6'h00, m, s}, 8'h01);
        usc_host_model_i.wr(8'h22, m, s);
        #1;
        check("load", {4'h0, m, s, requestToSend_n, terminalReady_n}, 8'h00);
        // a data write must leave the command register alone
        usc_host_model_i.dacc(1'h1, 8'h00);
        #1;
        check("dwrite", {6'h00, requestToSend_n, terminalReady_n}, 8'h00);
        $display("soft done");
    endtask
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // run needs under a hundred cycles; limit of 4000 cycles is far beyond that
    initial
    begin
        #20000;
        n_errors++;
        tally_and_finish;
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'h0;
        t_cmd;
        t_transmit_holding_free;
        t_errors;
        t_hunt;
        t_soft;
        tally_and_finish;
    end
endmodule // test_usc_status_command
